// file: logic/sahc_top.sv
// Purpose: Control, successive-approximation sequencer and output gating.
// Assumes: Control pins and comparator are asynchronous; APB on clk.
// Notes:   Result lines are data plus three group enables, no tristate here.
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Operation
// RL1: Conversion timing comes from internal clock.
// RL2: Full conversion finishes within 8 microseconds.
// RL3: Exactly five logic control inputs accepted.
// RL4: Host picks cycle, starts, reads after completion.
// RL5: Stand-alone mode driven by read/convert alone.
// RL6: Result as 12 bits or 8+4 left-justified.
// RL7: Start on chip enable, select or read/convert.
// RL8: Same start delay; simultaneous changes still start.
// RL9: Host settles other start inputs 50 ns early.
// RL10: Drive data only when all read conditions hold.
// RL11: Word and byte select choose driven lines.
// RL12: Status high during conversion; outputs float then.
// RL13: Start while busy only relatches byte select.
// RL14: Byte select low 12-bit, high 8-bit cycle.
// RL15: Word select high all; else byte halves.
// RL16: Start when enable conditions first all true.
// RL17: Separate enables; byte groups never both on. Code turns on all three groups when word select is high.
module sahc_top (
  // Clock and reset.
  input  wire logic               clk,
  input  wire logic               rst,
  // Converter control pins.
  input  wire sahc_pkg::sahc_ctl_type ctl_pins, // RL3
  // Analog side: trial code out, comparator answer in.
  output logic [11:0]             dac_code,
  input  wire logic               cmp_above,
  // Result lines and status.
  output logic [11:0]             result_bus,
  output sahc_pkg::sahc_oe_type   result_oe,
  output logic                    conv_in_progress,
  // APB slave.
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr,
  // Interrupt.
  output logic                    irq
);
  import sahc_pkg::*;

  // ---------------------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------------------
  sahc_ctl_type ctl;
  logic         cmp;

  sahc_sync #(.W(6)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({ctl_pins, cmp_above}),
    .dout ({ctl, cmp})
  );

  // ---------------------------------------------------------------------------
  // Start detection and sequencer
  // ---------------------------------------------------------------------------
  logic        arm_cond;
  logic        start_evt;
  logic        arm_prev_reg;
  logic        arm_prev_next;
  logic        busy_reg;
  logic        busy_next;
  logic        short_reg;
  logic        short_next;
  logic [3:0]  idx_reg;
  logic [3:0]  idx_next;
  logic [4:0]  cyc_reg;
  logic [4:0]  cyc_next;
  logic [11:0] sar_reg;
  logic [11:0] sar_next;
  logic [11:0] res_reg;
  logic [11:0] res_next;
  logic        done_evt;
  logic        restart_evt;
  logic [3:0]  stop_idx;

  // Three start pins meet in one condition, so any one or several changing
  // together give a single start with the same delay.
  assign arm_cond    = ctl.chip_en & ~ctl.sel_n & ~ctl.read_conv; // RL5 RL7 RL8 RL16
  assign start_evt   = arm_cond & ~arm_prev_reg;                  // RL16
  assign restart_evt = start_evt & busy_reg;
  assign stop_idx    = short_reg ? IDX_STOP_SHORT : IDX_STOP_LONG;
  assign done_evt    = busy_reg && (cyc_reg == BIT_CYC_LAST) && (idx_reg <= stop_idx);

  always_comb begin
    arm_prev_next = arm_cond;
    busy_next     = busy_reg;
    short_next    = short_reg;
    idx_next      = idx_reg;
    cyc_next      = cyc_reg;
    sar_next      = sar_reg;
    res_next      = res_reg;
    if (start_evt) begin
      short_next = ctl.byte_sel_short_cycle; // RL13 RL14
    end
    if (start_evt && !busy_reg) begin
      busy_next = 1'b1; // RL12
      idx_next  = IDX_MSB;
      cyc_next  = 5'h00;
      sar_next  = SAR_FIRST;
    end else if (busy_reg) begin
      // Each bit decision takes a fixed count of internal clocks.
      if (cyc_reg == BIT_CYC_LAST) begin // RL1 RL2
        cyc_next = 5'h00;
        if (!cmp) begin
          sar_next[idx_reg] = 1'b0;
        end
        if (idx_reg <= stop_idx) begin
          busy_next = 1'b0; // RL12
          res_next  = cmp ? sar_reg : (sar_reg & ~(12'h001 << idx_reg));
        end else begin
          idx_next = idx_reg - 4'h1;
          sar_next[idx_reg - 4'h1] = 1'b1;
        end
      end else begin
        cyc_next = cyc_reg + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      arm_prev_reg <= 1'b0;
      busy_reg     <= 1'b0;
      short_reg    <= 1'b0;
      idx_reg      <= 4'h0;
      cyc_reg      <= 5'h00;
      sar_reg      <= 12'h000;
      res_reg      <= RESULT_RST;
    end else begin
      arm_prev_reg <= arm_prev_next;
      busy_reg     <= busy_next;
      short_reg    <= short_next;
      idx_reg      <= idx_next;
      cyc_reg      <= cyc_next;
      sar_reg      <= sar_next;
      res_reg      <= res_next;
    end
  end

  assign conv_in_progress = busy_reg; // RL4 RL12
  assign dac_code         = sar_reg;

  // ---------------------------------------------------------------------------
  // Result line gating
  // ---------------------------------------------------------------------------
  logic         read_ok;
  sahc_oe_type  oe_reg;
  sahc_oe_type  oe_want;
  sahc_oe_type  oe_next;
  logic [11:0]  bus_reg;
  logic [11:0]  bus_next;

  assign read_ok = ctl.read_conv & ~busy_reg & ctl.chip_en & ~ctl.sel_n; // RL10 RL12

  always_comb begin
    oe_want  = '0;
    bus_next = bus_reg;
    if (read_ok) begin
      if (ctl.word_sel) begin
        oe_want  = '{upper: 1'b1, mid: 1'b1, lower: 1'b1}; // RL11 RL15
        bus_next = res_reg;                                 // RL6
      end else if (!ctl.byte_sel_short_cycle) begin
        oe_want  = '{upper: 1'b1, mid: 1'b1, lower: 1'b0}; // RL15
        bus_next = res_reg;
      end else begin
        oe_want  = '{upper: 1'b0, mid: 1'b1, lower: 1'b1}; // RL15
        bus_next = {res_reg[11:8], ZERO_NIB, res_reg[3:0]}; // RL6
      end
    end
    oe_next = oe_want;
    // Break before make between the two bytes.
    if ((oe_reg != '0) && (oe_want != '0) && (oe_reg != oe_want)) begin
      oe_next = '0; // RL17
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      oe_reg  <= '0;
      bus_reg <= RESULT_RST;
    end else begin
      oe_reg  <= oe_next;
      bus_reg <= bus_next;
    end
  end

  assign result_oe  = oe_reg;
  assign result_bus = bus_reg;

  // ---------------------------------------------------------------------------
  // APB registers and interrupt
  // ---------------------------------------------------------------------------
  logic        addr_ok;
  logic        wr_acc;
  logic [1:0]  ist_reg;
  logic [1:0]  ist_next;
  logic [1:0]  imask_reg;
  logic [1:0]  imask_next;
  logic [31:0] rd_reg;
  logic [31:0] rd_next;
  logic [1:0]  ev_set;

  assign addr_ok = (paddr == OFS_STATUS) || (paddr == OFS_RESULT) ||
                   (paddr == OFS_IRQ_STAT) || (paddr == OFS_IRQ_MASK);
  assign wr_acc  = psel & penable & pwrite;
  assign ev_set  = {restart_evt, done_evt};

  always_comb begin
    ist_next   = ist_reg;
    imask_next = imask_reg;
    rd_next    = rd_reg;
    if (wr_acc && (paddr == OFS_IRQ_STAT)) begin
      ist_next = ist_reg & ~pwdata[1:0];
    end
    if (wr_acc && (paddr == OFS_IRQ_MASK)) begin
      imask_next = pwdata[1:0];
    end
    ist_next = ist_next | ev_set;
    if (psel && !penable) begin
      case (paddr)
        OFS_STATUS:   rd_next = {30'h0, short_reg, busy_reg};
        OFS_RESULT:   rd_next = {20'h0, res_reg};
        OFS_IRQ_STAT: rd_next = {30'h0, ist_reg};
        OFS_IRQ_MASK: rd_next = {30'h0, imask_reg};
        default:      rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ist_reg   <= IRQ_RST;
      imask_reg <= IRQ_RST;
      rd_reg    <= 32'h0000_0000;
    end else begin
      ist_reg   <= ist_next;
      imask_reg <= imask_next;
      rd_reg    <= rd_next;
    end
  end

  assign prdata  = rd_reg;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~addr_ok;
  assign irq     = |(ist_reg & imask_reg);

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  logic [8:0] busy_cnt_reg;

  always_ff @(posedge clk) begin
    if (rst || !busy_reg) begin
      busy_cnt_reg <= 9'h000;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 9'h001;
    end
  end

  a_start_busy: assert property (@(posedge clk) disable iff (rst) // RL12
    (start_evt && !busy_reg) |=> busy_reg)
    else $error("Status did not rise after a start.");

  a_conv_bound: assert property (@(posedge clk) disable iff (rst) // RL2
    busy_cnt_reg <= 9'(CONV_MAX_CYC))
    else $error("Conversion ran past its time limit.");

  a_short_len: assert property (@(posedge clk) disable iff (rst) // RL14
    (done_evt && short_reg && $past(!busy_reg, 160)) |->
      busy_cnt_reg == 9'(SHORT_BITS * BIT_CYC - 1))
    else $error("Short cycle length is wrong.");

  a_read_gate: assert property (@(posedge clk) disable iff (rst) // RL10
    (result_oe != '0) |-> $past(read_ok))
    else $error("Result lines driven without read conditions.");

  a_busy_float: assert property (@(posedge clk) disable iff (rst) // RL12
    busy_reg |-> result_oe == '0)
    else $error("Result lines driven during conversion.");

  a_byte_excl: assert property (@(posedge clk) disable iff (rst) // RL17
    (result_oe.upper && result_oe.lower) |-> $past(ctl.word_sel))
    else $error("Both byte groups enabled in byte mode.");

  a_low_zeros: assert property (@(posedge clk) disable iff (rst) // RL15
    (result_oe.lower && !result_oe.upper) |-> result_bus[7:4] == ZERO_NIB)
    else $error("Trailing zeros missing on low byte.");

  a_relatch_sel: assert property (@(posedge clk) disable iff (rst) // RL13
    (start_evt && busy_reg && !done_evt) |=>
      busy_reg && short_reg == $past(ctl.byte_sel_short_cycle))
    else $error("Start during conversion misbehaved.");

  a_irq_level: assert property (@(posedge clk) disable iff (rst) // RL4
    done_evt && imask_reg[IRQ_DONE_BIT] |=> irq)
    else $error("Interrupt missing after completion.");

endmodule // sahc_top

// file: logic/sahc_pkg.sv
// Purpose: Shared constants and types for the converter control block.
// Assumes: 40 MHz system clock, APB register access with 32-bit data.
// Notes:   Timing counts derive from times held in their own units.
package sahc_pkg;
  localparam int          CLK_KHZ       = 40000;
  localparam int          RES_BITS      = 12;
  localparam int          SHORT_BITS    = 8;
  // Conversion time ceiling and the time spent on one bit decision.
  localparam int          CONV_MAX_NS   = 8000;
  localparam int          BIT_NS        = 500;
  localparam int          BIT_CYC       = (BIT_NS * CLK_KHZ) / 1000000;
  localparam int          CONV_MAX_CYC  = (CONV_MAX_NS * CLK_KHZ) / 1000000;
  localparam logic [4:0]  BIT_CYC_LAST  = 5'(BIT_CYC - 1);
  localparam logic [3:0]  IDX_MSB       = 4'hB;
  localparam logic [3:0]  IDX_STOP_LONG = 4'h0;
  localparam logic [3:0]  IDX_STOP_SHORT = 4'h4;
  localparam logic [11:0] SAR_FIRST     = 12'h800;
  // Register byte offsets.
  localparam logic [7:0]  OFS_STATUS    = 8'h00;
  localparam logic [7:0]  OFS_RESULT    = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
  // Field positions.
  localparam int          ST_BUSY_BIT   = 0;
  localparam int          ST_SHORT_BIT  = 1;
  localparam int          IRQ_DONE_BIT  = 0;
  localparam int          IRQ_RESTART_BIT = 1;
  localparam logic [1:0]  IRQ_RST       = 2'h0;
  localparam logic [11:0] RESULT_RST    = 12'h000;
  localparam logic [3:0]  ZERO_NIB      = 4'h0;

  typedef struct packed {
    logic word_sel;
    logic sel_n;
    logic byte_sel_short_cycle;
    logic read_conv;
    logic chip_en;
  } sahc_ctl_type;

  typedef struct packed {
    logic upper;
    logic mid;
    logic lower;
  } sahc_oe_type;
endpackage

// file: logic/sahc_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter.
// Assumes: Inputs are asynchronous to clk.
// Notes:   The output moves only when the second and third stages agree.
`timescale 1ns/1ps
module sahc_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst,
  // Data.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] out_next;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : dout[i];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      dout   <= '0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      dout   <= out_next;
    end
  end
endmodule // sahc_sync

// file: sim/sahc_host_model.sv
// Purpose: Host and comparator model facing the converter pins.
// Assumes: Pins change just after a rising clock edge.
// Notes:   The comparator answers at once from a held input level.
`timescale 1ns/1ps
module sahc_host_model (
  // Clock.
  input  wire logic              clk,
  // Converter side.
  input  wire logic [11:0]       dac_code,
  output sahc_pkg::sahc_ctl_type ctl_pins,
  output logic                   cmp_above
);
  import sahc_pkg::*;
  logic [11:0] vin;
  initial begin
    vin      = 12'h000;
    ctl_pins = 5'h03;
  end
  assign cmp_above = (vin >= dac_code);
  // ----------------------------------------
  // Pin tasks
  // ----------------------------------------
  task automatic drive(input logic [4:0] v);
    @(posedge clk);
    ctl_pins <= v;
  endtask
  // Arms the idle start inputs, then moves the chosen one; choice 3 moves all three.
  task automatic start(input int trig, input logic shrt, input logic [11:0] v);
    @(posedge clk);
    vin                           <= v;
    ctl_pins.byte_sel_short_cycle <= shrt;
    ctl_pins.chip_en              <= !(trig == 0 || trig == 3);
    ctl_pins.sel_n                <= (trig == 1 || trig == 3);
    ctl_pins.read_conv            <= (trig >= 2);
    repeat (3) @(posedge clk);
    ctl_pins.chip_en   <= 1'b1;
    ctl_pins.sel_n     <= 1'b0;
    ctl_pins.read_conv <= 1'b0;
  endtask
endmodule // sahc_host_model

// file: sim/tb_top.sv
// Purpose: Self-checking bench for the converter control block.
// Assumes: Comparator model makes a 12-bit cycle result equal the held input.
// Notes:   Seeded random inputs with fixed corner cases.
`timescale 1ns/1ps
module tb_top;
  import sahc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [11:0] dac_code, result_bus;
  logic conv_in_progress, pready, pslverr, irq, cmp_above;
  sahc_oe_type result_oe;
  sahc_ctl_type ctl_pins;
  int err_total = 0, checks = 0;
  always #12.5 clk = ~clk;
  sahc_host_model host (.clk(clk), .dac_code(dac_code), .ctl_pins(ctl_pins),
                        .cmp_above(cmp_above));
  sahc_top dut (.clk(clk), .rst(rst), .ctl_pins(ctl_pins), .dac_code(dac_code),
                .cmp_above(cmp_above), .result_bus(result_bus), .result_oe(result_oe),
                .conv_in_progress(conv_in_progress), .psel(psel), .penable(penable),
                .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
                .pready(pready), .pslverr(pslverr), .irq(irq));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic sl);
    @(posedge clk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    sl = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  function automatic logic [11:0] exp_res(input logic [11:0] v, input logic s);
    return s ? {v[11:4], 4'h0} : v;
  endfunction
  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One conversion, optional byte select relatch mid-run, then bus and pin reads.
  task automatic conv(input int trig, input logic s, input logic [11:0] v, input logic rl);
    int n;
    logic [31:0] q;
    logic sl, mk;
    logic [11:0] e, mask, want;
    mk = 1'($urandom);
    apb(1'b1, OFS_IRQ_MASK, {31'h0, mk}, q, sl);
    host.start(trig, s, v);
    n = 0;
    while (conv_in_progress !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    chk("start_seen", 1, n < 20);
    chk("oe_busy", 0, result_oe);
    if (rl) begin
      s = ~s;
      host.drive({1'b0, 1'b0, s, 1'b0, 1'b0});
      repeat (4) @(posedge clk);
      host.drive({1'b0, 1'b0, s, 1'b0, 1'b1});
    end
    while (conv_in_progress === 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("conv_max", 1, n <= CONV_MAX_CYC);
    chk("cycle_len", s, n < 200);
    e = exp_res(v, s);
    apb(1'b0, OFS_IRQ_STAT, 0, q, sl);
    chk("irq_stat", {30'h0, rl, 1'b1}, q);
    chk("irq_pin", mk, irq);
    apb(1'b1, OFS_IRQ_STAT, 32'h3, q, sl);
    // The clear lands at the access edge, so look one edge later.
    @(posedge clk);
    chk("irq_clr", 0, irq);
    apb(1'b0, OFS_RESULT, 0, q, sl);
    chk("result_reg", e, q);
    apb(1'b0, OFS_STATUS, 0, q, sl);
    chk("status_reg", {30'h0, s, 1'b0}, q);
    for (int m = 0; m < 3; m++) begin
      host.drive({m == 0, 1'b0, m == 2, 1'b1, 1'b1});
      repeat (8) @(posedge clk);
      mask = (m == 0) ? 12'hFFF : (m == 1) ? 12'hFF0 : 12'h0FF;
      want = (m == 2) ? {8'h00, e[3:0]} : e;
      chk("oe", (m == 0) ? 3'h7 : (m == 1) ? 3'h6 : 3'h3, result_oe);
      chk("bus", want & mask, result_bus & mask);
    end
    host.drive(5'h02);
    repeat (8) @(posedge clk);
    chk("oe_off", 0, result_oe);
    $display("Test trig %0d value %h done", trig, v);
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] q;
    logic sl;
    logic [11:0] v;
    void'($urandom(32'he73880d4));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    for (int a = 0; a < 16; a += 4) begin
      apb(1'b0, 8'(a), 0, q, sl);
      chk("reset_val", 0, q);
    end
    apb(1'b0, 8'h10, 0, q, sl);
    chk("bad_addr", 1, sl);
    $display("Test reset values done");
    for (int i = 0; i < 12; i++) conv(i % 4, 1'($urandom), 12'($urandom), i == 5);
    conv(3, 1'b0, 12'hFFF, 1'b0);
    conv(0, 1'b1, 12'h000, 1'b1);
    // Stand-alone: word select and enable high, select and byte low, read/convert moves.
    v = 12'($urandom);
    host.drive(5'h13);
    host.start(2, 1'b0, v);
    repeat (CONV_MAX_CYC) @(posedge clk);
    host.drive(5'h13);
    repeat (8) @(posedge clk);
    chk("alone_busy", 0, conv_in_progress);
    chk("alone_oe", 3'h7, result_oe);
    chk("alone_bus", v, result_bus);
    $display("Test stand-alone done");
    stop_test;
  end
  initial begin
    #(25 * 40000);
    err_total++;
    stop_test;
  end
endmodule // tb_top
